// ==== src/bfap_defs.svh ====
// Offsets, field positions, reset values and widths for the flash access protection block.
`ifndef BFAP_DEFS_SVH
`define BFAP_DEFS_SVH

// Word address width of the program flash and of the core's program counter.
`define BFAP_FADDR_W        16
// AXI4-Lite address width and register byte offsets.
`define BFAP_AXI_AW         8
`define BFAP_OFF_CTRL       8'h00
`define BFAP_OFF_LOCK       8'h04
`define BFAP_OFF_STAT       8'h08
// Control register fields.
`define BFAP_CTRL_BUSY      0
`define BFAP_CTRL_REEN      1
`define BFAP_CTRL_VECLDR    2
// Lock register fields: two bits each, a one means unprogrammed.
`define BFAP_LOCK_APP_LO    0
`define BFAP_LOCK_LDR_LO    2
`define BFAP_LOCK_GEN_LO    4
`define BFAP_LOCK_W         6
`define BFAP_LOCK_RST       6'h3F
// Status register fields.
`define BFAP_STAT_HALT      0
`define BFAP_STAT_PROG      1
`define BFAP_STAT_FUSE_LO   4
`define BFAP_STAT_REF_LO    8
`define BFAP_REF_W          8
// AXI responses.
`define BFAP_RESP_OKAY      2'h0
`define BFAP_RESP_SLVERR    2'h2
// Smallest loader section, in words; the largest is eight times this.
`define BFAP_LDR_MIN_WORDS  512

`endif

// ==== src/bfap_pkg.sv ====
// Types shared by the flash access protection block and its users.
`include "bfap_defs.svh"
package bfap_pkg;

   // One program memory operation offered by the core.
   typedef struct packed {
      logic                     is_store;
      logic [`BFAP_FADDR_W-1:0] target;
      logic [`BFAP_FADDR_W-1:0] pc;
   } bfap_op_t;

   // Answer to one operation.
   typedef struct packed {
      logic ack;
      logic ok;
      logic rd_invalid;
   } bfap_ans_t;

   // Programming sequencer states.
   typedef enum logic {
      BFAP_IDLE,
      BFAP_PROG
   } bfap_state_t;

endpackage : bfap_pkg

// ==== src/bfap_top.sv ====
// Access control and read-while-write arbitration for flash self-programming.
`timescale 1ns/10ps
`include "bfap_defs.svh"

module bfap_top
   import bfap_pkg::*;
#(
   parameter int FLASH_WORDS = 1 << `BFAP_FADDR_W
) (
   input  wire logic                      core_clk,
   input  wire logic                      rstn,
   // Core operations and fetch address.
   input  wire bfap_op_t                  op,
   input  wire logic                      op_valid,
   output bfap_ans_t                      ans,
   output logic                           core_halt,
   output logic                           irq_block,
   // Flash engine.
   output logic                           flash_start,
   output logic [`BFAP_FADDR_W-1:0]       flash_page_addr,
   input  wire logic                      flash_done,
   // Strap fuses and external programming port.
   input  wire logic [1:0]                loader_size_fuses,
   input  wire logic                      chip_erase,
   input  wire logic                      ext_lock_wr,
   input  wire logic [`BFAP_LOCK_W-1:0]   ext_lock_data,
   // AXI4-Lite slave.
   input  wire logic [`BFAP_AXI_AW-1:0]   s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [`BFAP_AXI_AW-1:0]   s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready
);

   localparam int LDR_MIN  = `BFAP_LDR_MIN_WORDS;
   localparam int STALL_SZ = LDR_MIN * 8;
   localparam logic [`BFAP_FADDR_W-1:0] STALL_BASE = `BFAP_FADDR_W'(FLASH_WORDS - STALL_SZ);

   bfap_state_t                state_r;
   logic [1:0]                 fuse_s1_r, fuse_s2_r;
   logic [`BFAP_FADDR_W-1:0]   ldr_base_r;
   logic [`BFAP_LOCK_W-1:0]    lock_r;
   logic                       busy_r, vec_ldr_r, halt_r, start_r;
   logic [`BFAP_FADDR_W-1:0]   page_r;
   logic [`BFAP_REF_W-1:0]     ref_cnt_r;
   bfap_ans_t                  ans_r;
   logic                       irq_r;
   logic                       aw_got_r, w_got_r, awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [`BFAP_AXI_AW-1:0]    awaddr_r;
   logic [31:0]                wdata_r, rdata_r;
   logic [1:0]                 bresp_r, rresp_r;
   logic                       wstrb0_r;

   // Fuse straps cross in through two flip-flops before use.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         fuse_s1_r <= 2'h0;
         fuse_s2_r <= 2'h0;
      end else begin
         fuse_s1_r <= loader_size_fuses;
         fuse_s2_r <= fuse_s1_r;
      end
   end

   // Loader size grows as the fuse value falls; the largest fills the stall section.
   wire [`BFAP_FADDR_W-1:0] ldr_size_w = `BFAP_FADDR_W'(LDR_MIN << (2'h3 - fuse_s2_r));
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ldr_base_r <= STALL_BASE;
      end else begin
         ldr_base_r <= `BFAP_FADDR_W'(FLASH_WORDS) - ldr_size_w;
      end
   end

   // Section membership of the executing code and of the target page.
   wire pc_in_ldr   = (op.pc >= ldr_base_r);
   wire tgt_in_ldr  = (op.target >= ldr_base_r);
   wire tgt_stall   = (op.target >= STALL_BASE);

   // Lock decode: the low bit programmed blocks writes, the high bit programmed blocks reads.
   wire app_wr_blk  = ~lock_r[`BFAP_LOCK_APP_LO];
   wire app_rd_blk  = ~lock_r[`BFAP_LOCK_APP_LO+1];
   wire ldr_wr_blk  = ~lock_r[`BFAP_LOCK_LDR_LO];
   wire ldr_rd_blk  = ~lock_r[`BFAP_LOCK_LDR_LO+1];
   wire gen_wr_blk  = ~lock_r[`BFAP_LOCK_GEN_LO];
   wire gen_rd_blk  = ~lock_r[`BFAP_LOCK_GEN_LO+1];

   // Store permission: loader code only, any page, subject to locks and no run in progress.
   wire st_ok = pc_in_ldr && !gen_wr_blk
             && (tgt_in_ldr ? !ldr_wr_blk : !app_wr_blk)
             && (state_r == BFAP_IDLE);
   // Load permission: cross-section reads follow the read-lock bits.
   wire ld_ok = !gen_rd_blk
             && !(pc_in_ldr && !tgt_in_ldr && app_rd_blk)
             && !(!pc_in_ldr && tgt_in_ldr && ldr_rd_blk);
   wire op_ok    = op.is_store ? st_ok : ld_ok;
   wire go       = op_valid && op.is_store && st_ok;
   wire rd_inval = op_valid && !op.is_store && ld_ok && busy_r && !tgt_stall;

   // Interrupts are masked when the vectors sit in the other section and the executing section is read-locked.
   wire irq_nxt = ( vec_ldr_r && app_rd_blk && !pc_in_ldr)
               || (!vec_ldr_r && ldr_rd_blk &&  pc_in_ldr);

   // Register bus decode.
   wire do_wr    = aw_got_r && w_got_r && !bvalid_r;
   wire wr_ctrl  = do_wr && (awaddr_r == `BFAP_OFF_CTRL);
   wire wr_lock  = do_wr && (awaddr_r == `BFAP_OFF_LOCK);
   wire wr_hit   = wr_ctrl || wr_lock || (awaddr_r == `BFAP_OFF_STAT);
   wire reen     = wr_ctrl && wstrb0_r && wdata_r[`BFAP_CTRL_REEN];
   wire rd_take  = s_axi_arvalid && arready_r;

   // Programming sequencer: state and halt follow the run; done drops halt on the next edge.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_r <= BFAP_IDLE;
         halt_r  <= 1'b0;
         start_r <= 1'b0;
         page_r  <= '0;
      end else begin
         start_r <= go;
         if (go) begin
            state_r <= BFAP_PROG;
            halt_r  <= tgt_stall;
            page_r  <= op.target;
         end else if (state_r == BFAP_PROG && flash_done) begin
            state_r <= BFAP_IDLE;
            halt_r  <= 1'b0;
         end
      end
   end

   // Busy flag: set by a start, cleared only by an idle reenable write; set wins.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         busy_r <= 1'b0;
      end else if (go) begin
         busy_r <= 1'b1;
      end else if (reen && state_r == BFAP_IDLE) begin
         busy_r <= 1'b0;
      end
   end

   // Lock bits only move toward programmed; only chip erase or reset returns them.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         lock_r <= `BFAP_LOCK_RST;
      end else if (chip_erase) begin
         lock_r <= `BFAP_LOCK_RST;
      end else begin
         lock_r <= lock_r & (ext_lock_wr ? ext_lock_data : '1)
                          & ((wr_lock && wstrb0_r) ? wdata_r[`BFAP_LOCK_W-1:0] : '1);
      end
   end

   // Answers to the core and the refused-operation count.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ans_r     <= '0;
         irq_r     <= 1'b0;
         ref_cnt_r <= '0;
         vec_ldr_r <= 1'b0;
      end else begin
         ans_r <= '{ack: op_valid, ok: op_valid && op_ok, rd_invalid: rd_inval};
         irq_r <= irq_nxt;
         if (op_valid && !op_ok) begin
            ref_cnt_r <= ref_cnt_r + 1'b1;
         end
         if (wr_ctrl && wstrb0_r) begin
            vec_ldr_r <= wdata_r[`BFAP_CTRL_VECLDR];
         end
      end
   end

   // AXI write channels: each is taken once, the response follows both.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         aw_got_r  <= 1'b0;
         w_got_r   <= 1'b0;
         awready_r <= 1'b1;
         wready_r  <= 1'b1;
         bvalid_r  <= 1'b0;
         bresp_r   <= `BFAP_RESP_OKAY;
         awaddr_r  <= '0;
         wdata_r   <= '0;
         wstrb0_r  <= 1'b0;
      end else begin
         if (s_axi_awvalid && awready_r) begin
            aw_got_r  <= 1'b1;
            awready_r <= 1'b0;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && wready_r) begin
            w_got_r  <= 1'b1;
            wready_r <= 1'b0;
            wdata_r  <= s_axi_wdata;
            wstrb0_r <= s_axi_wstrb[0]; // The master may drop the strobe once W is taken.
         end
         if (do_wr) begin
            aw_got_r <= 1'b0;
            w_got_r  <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r  <= wr_hit ? `BFAP_RESP_OKAY : `BFAP_RESP_SLVERR;
         end
         if (bvalid_r && s_axi_bready) begin
            bvalid_r  <= 1'b0;
            awready_r <= 1'b1;
            wready_r  <= 1'b1;
         end
      end
   end

   // Read data views.
   wire [31:0] ctrl_view = {29'h0, vec_ldr_r, 1'b0, busy_r};
   wire [31:0] lock_view = {26'h0, lock_r};
   wire [31:0] stat_view = {16'h0, ref_cnt_r, 2'h0, fuse_s2_r, 2'h0, (state_r == BFAP_PROG), halt_r};

   // AXI read channel: one beat, answered the cycle after the address is taken.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         arready_r <= 1'b1;
         rvalid_r  <= 1'b0;
         rdata_r   <= '0;
         rresp_r   <= `BFAP_RESP_OKAY;
      end else if (rd_take) begin
         arready_r <= 1'b0;
         rvalid_r  <= 1'b1;
         rresp_r   <= `BFAP_RESP_OKAY;
         unique case (s_axi_araddr)
            `BFAP_OFF_CTRL: rdata_r <= ctrl_view;
            `BFAP_OFF_LOCK: rdata_r <= lock_view;
            `BFAP_OFF_STAT: rdata_r <= stat_view;
            default: begin
               rdata_r <= '0;
               rresp_r <= `BFAP_RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r  <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   // Outputs, all straight from flip-flops.
   assign ans             = ans_r;
   assign core_halt       = halt_r;
   assign irq_block       = irq_r;
   assign flash_start     = start_r;
   assign flash_page_addr = page_r;
   assign s_axi_awready   = awready_r;
   assign s_axi_wready    = wready_r;
   assign s_axi_bvalid    = bvalid_r;
   assign s_axi_bresp     = bresp_r;
   assign s_axi_arready   = arready_r;
   assign s_axi_rvalid    = rvalid_r;
   assign s_axi_rdata     = rdata_r;
   assign s_axi_rresp     = rresp_r;

   // Checks on the sequencer, flags and lock decoding.
   a_app_store_none: assert property (@(posedge core_clk) disable iff (!rstn)
      (op_valid && op.is_store && !pc_in_ldr) |=> (!start_r && !ans.ok))
      else $error("Store from application code was granted.");
   a_gen_wlock: assert property (@(posedge core_clk) disable iff (!rstn)
      (op_valid && op.is_store && !lock_r[`BFAP_LOCK_GEN_LO]) |=> !flash_start)
      else $error("Store started under general write lock.");
   a_gen_rlock: assert property (@(posedge core_clk) disable iff (!rstn)
      (op_valid && !op.is_store && !lock_r[`BFAP_LOCK_GEN_LO+1]) |=> (ans.ack && !ans.ok))
      else $error("Load granted under general read lock.");
   a_stall_halt: assert property (@(posedge core_clk) disable iff (!rstn)
      core_halt == (state_r == BFAP_PROG && page_r >= STALL_BASE))
      else $error("Core not halted for stall section programming.");
   a_rww_run: assert property (@(posedge core_clk) disable iff (!rstn)
      (go && !tgt_stall) |=> !core_halt)
      else $error("Core halted for concurrent section programming.");
   a_halt_release: assert property (@(posedge core_clk) disable iff (!rstn)
      (state_r == BFAP_PROG && flash_done) |=> (!core_halt && state_r == BFAP_IDLE))
      else $error("Halt not released when programming finished.");
   a_busy_hold: assert property (@(posedge core_clk) disable iff (!rstn)
      (busy_r && !reen) |=> busy_r)
      else $error("Busy flag dropped without a reenable write.");
   a_busy_set: assert property (@(posedge core_clk) disable iff (!rstn)
      go |=> (busy_r && state_r == BFAP_PROG))
      else $error("Busy flag not set by a started programming run.");
   a_lock_mono: assert property (@(posedge core_clk) disable iff (!rstn)
      !chip_erase |=> ((lock_r & ~$past(lock_r)) == '0))
      else $error("Lock bit returned to unprogrammed without chip erase.");
   a_refuse_quiet: assert property (@(posedge core_clk) disable iff (!rstn)
      (op_valid && !op_ok && state_r == BFAP_IDLE && !reen) |=> (!flash_start && $stable(busy_r) && !core_halt))
      else $error("Refused operation had an effect.");

endmodule : bfap_top

// ==== dv/bfap_core_model.sv ====
// Model of the processor core and flash engine facing the protection block.
`timescale 1ns/10ps
`include "bfap_defs.svh"
module bfap_core_model
   import bfap_pkg::*;
#(
   parameter int RUN_CYCLES = 40
) (
   input  wire logic      core_clk,
   input  wire logic      rstn,
   output bfap_op_t       op,
   output logic           op_valid,
   input  wire bfap_ans_t ans,
   input  wire logic      flash_start,
   output logic           flash_done
);
   int        run_cnt;
   bfap_ans_t ans_seen;
   logic      start_seen;

   // Operation lines stay idle until the first request.
   initial begin
      op       = '0;
      op_valid = 1'b0;
   end

   // Offers one operation for a single cycle and keeps the answer that follows it.
   task automatic issue(input logic st, input logic [`BFAP_FADDR_W-1:0] tgt, input logic [`BFAP_FADDR_W-1:0] pc);
      @(posedge core_clk);
      op       <= '{is_store: st, target: tgt, pc: pc};
      op_valid <= 1'b1;
      @(posedge core_clk);
      op_valid <= 1'b0;
      #1;
      ans_seen   = ans;
      start_seen = flash_start;
   endtask : issue

   // The flash engine ends every run a fixed time after its start.
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         run_cnt    <= 0;
         flash_done <= 1'b0;
      end else begin
         flash_done <= (run_cnt == 1);
         if (flash_start) begin
            run_cnt <= RUN_CYCLES;
         end else if (run_cnt != 0) begin
            run_cnt <= run_cnt - 1;
         end
      end
   end
endmodule : bfap_core_model

// ==== dv/tb.sv ====
// Self-checking bench for the flash access protection block.
`timescale 1ns/10ps
`include "bfap_defs.svh"
module tb;
   logic                core_clk, rstn, op_valid, core_halt, irq_block, flash_start, flash_done;
   logic                chip_erase, ext_lock_wr;
   logic [15:0]         flash_page_addr;
   logic [1:0]          loader_size_fuses, s_axi_bresp, s_axi_rresp, rsp;
   logic [5:0]          ext_lock_data;
   logic [7:0]          s_axi_awaddr, s_axi_araddr;
   logic [31:0]         s_axi_wdata, s_axi_rdata, rd;
   logic                s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic                s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   bfap_pkg::bfap_op_t  op;
   bfap_pkg::bfap_ans_t ans;
   int                  fail_count = 0, cmp_count = 0, cyc = 0;

   // Block under test and the core model on its far side.
   bfap_top DUT (.core_clk(core_clk), .rstn(rstn), .op(op), .op_valid(op_valid), .ans(ans),
      .core_halt(core_halt), .irq_block(irq_block), .flash_start(flash_start),
      .flash_page_addr(flash_page_addr), .flash_done(flash_done), .loader_size_fuses(loader_size_fuses),
      .chip_erase(chip_erase), .ext_lock_wr(ext_lock_wr), .ext_lock_data(ext_lock_data),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
   bfap_core_model core (.core_clk(core_clk), .rstn(rstn), .op(op), .op_valid(op_valid), .ans(ans),
      .flash_start(flash_start), .flash_done(flash_done));

   // A 40 MHz clock.
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   // Cuts a hung run short well past the expected length.
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         fail_count++;
         give_verdict();
      end
   end

   // Compares one value and reports a difference.
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      cmp_count++;
      if (s !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask : chk

   // One register write; address and data are offered together and released as taken.
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w;
      @(posedge core_clk);
      {aw, w} = 2'b11;
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      while (aw | w) begin
         @(posedge core_clk);
         if (aw && s_axi_awready === 1'b1) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready === 1'b1) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask : axw

   // One register read.
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge core_clk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do @(posedge core_clk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask : axr

   // Pulses chip erase for one cycle.
   task automatic erase();
      @(posedge core_clk);
      chip_erase <= 1'b1;
      @(posedge core_clk);
      chip_erase <= 1'b0;
   endtask : erase

   // Waits for the end of a run; the halt must equal h while done stands and drop on the next edge.
   task automatic wait_done(input logic h);
      do begin
         @(posedge core_clk);
         #1;
      end while (flash_done !== 1'b1);
      chk("halt_run", core_halt, h);
      @(posedge core_clk);
      #1;
      chk("halt_end", core_halt, 1'b0);
   endtask : wait_done

   // Sets one lock pattern from the erased state and tries one operation.
   task automatic lk_case(input logic [5:0] v, input logic st, input logic [15:0] t, input logic [15:0] pc,
                          input logic e);
      erase();
      axw(`BFAP_OFF_LOCK, {26'h0, v}, rsp);
      chk("lock_wr_resp", rsp, `BFAP_RESP_OKAY);
      core.issue(st, t, pc);
      chk("lock_ack", core.ans_seen.ack, 1'b1);
      chk("lock_ok", core.ans_seen.ok, e);
      chk("lock_start", core.start_seen, e & st);
      chk("lock_halt", core_halt, 1'b0);
   endtask : lk_case

   // Prints the counts and the verdict, then ends the run.
   task automatic give_verdict();
      $display("checks %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : give_verdict

   // Main sequence.
   initial begin
      {rstn, chip_erase, ext_lock_wr, ext_lock_data, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      loader_size_fuses = 2'b11;
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      axr(`BFAP_OFF_LOCK, rd, rsp);
      chk("lock_rst", rd, 32'h0000_003F);
      chk("lock_rd_resp", rsp, `BFAP_RESP_OKAY);
      axr(`BFAP_OFF_STAT, rd, rsp);
      chk("stat_rst", rd, 32'h0000_0030);
      axr(8'h0C, rd, rsp);
      chk("rd_unmapped", rsp, `BFAP_RESP_SLVERR);
      axw(8'h0C, 32'h0000_0001, rsp);
      chk("wr_unmapped", rsp, `BFAP_RESP_SLVERR);
      $display("test reset_regs done");
      core.issue(1'b1, 16'h0200, 16'hFE10);
      chk("st_ok", core.ans_seen.ok, 1'b1);
      chk("st_page", flash_page_addr, 16'h0200);
      chk("st_nohalt", core_halt, 1'b0);
      axr(`BFAP_OFF_CTRL, rd, rsp);
      chk("busy_run", rd, 32'h0000_0001);
      core.issue(1'b0, 16'h0300, 16'hFE10);
      chk("ld_inval", core.ans_seen.rd_invalid, 1'b1);
      core.issue(1'b0, 16'hF800, 16'hFE10);
      chk("ld_stall", core.ans_seen.rd_invalid, 1'b0);
      core.issue(1'b1, 16'h0400, 16'hFE10);
      chk("st_during", core.start_seen, 1'b0);
      wait_done(1'b0);
      core.issue(1'b0, 16'h0300, 16'hFE10);
      chk("ld_still_inval", core.ans_seen.rd_invalid, 1'b1);
      axr(`BFAP_OFF_CTRL, rd, rsp);
      chk("busy_after", rd, 32'h0000_0001);
      axw(`BFAP_OFF_CTRL, 32'h0000_0002, rsp);
      axr(`BFAP_OFF_CTRL, rd, rsp);
      chk("busy_clr", rd, 32'h0000_0000);
      core.issue(1'b0, 16'h0300, 16'hFE10);
      chk("ld_valid", core.ans_seen.rd_invalid, 1'b0);
      axr(`BFAP_OFF_STAT, rd, rsp);
      chk("stat_ref", rd, 32'h0000_0130);
      $display("test concurrent_run done");
      core.issue(1'b1, 16'hF800, 16'hF100);
      chk("st_app", core.ans_seen.ok, 1'b0);
      loader_size_fuses <= 2'b00;
      repeat (4) @(posedge core_clk);
      core.issue(1'b1, 16'hF800, 16'hF100);
      chk("st_fuse", core.ans_seen.ok, 1'b1);
      chk("st_halt", core_halt, 1'b1);
      wait_done(1'b1);
      core.issue(1'b1, 16'hFF00, 16'hF100);
      chk("st_self", core.start_seen, 1'b1);
      chk("self_halt", core_halt, 1'b1);
      wait_done(1'b1);
      axw(`BFAP_OFF_CTRL, 32'h0000_0002, rsp);
      loader_size_fuses <= 2'b11;
      repeat (4) @(posedge core_clk);
      $display("test stall_run done");
      lk_case(6'h3E, 1'b1, 16'h0200, 16'hFE10, 1'b0);
      lk_case(6'h3E, 1'b0, 16'h0200, 16'hFE10, 1'b1);
      lk_case(6'h3D, 1'b0, 16'h0200, 16'hFE10, 1'b0);
      lk_case(6'h3C, 1'b1, 16'h0200, 16'hFE10, 1'b0);
      lk_case(6'h3C, 1'b0, 16'h0200, 16'hFE10, 1'b0);
      lk_case(6'h3B, 1'b1, 16'hFF00, 16'hFE10, 1'b0);
      lk_case(6'h37, 1'b0, 16'hFF00, 16'h0100, 1'b0);
      lk_case(6'h33, 1'b0, 16'hFF00, 16'h0100, 1'b0);
      lk_case(6'h2F, 1'b1, 16'h0200, 16'hFE10, 1'b0);
      lk_case(6'h2F, 1'b0, 16'h0200, 16'hFE10, 1'b1);
      lk_case(6'h0F, 1'b0, 16'h0200, 16'hFE10, 1'b0);
      lk_case(6'h0F, 1'b1, 16'h0200, 16'hFE10, 1'b0);
      lk_case(6'h33, 1'b1, 16'hFF00, 16'hFE10, 1'b0);
      repeat (2) @(posedge core_clk);
      #1;
      chk("irq_ldr", irq_block, 1'b1);
      $display("test lock_table done");
      lk_case(6'h3C, 1'b0, 16'h0200, 16'h0100, 1'b1);
      repeat (2) @(posedge core_clk);
      #1;
      chk("irq_vec_app", irq_block, 1'b0);
      axw(`BFAP_OFF_CTRL, 32'h0000_0004, rsp);
      repeat (2) @(posedge core_clk);
      #1;
      chk("irq_app", irq_block, 1'b1);
      axw(`BFAP_OFF_LOCK, 32'h0000_003F, rsp);
      ext_lock_data <= 6'h2F;
      ext_lock_wr   <= 1'b1;
      @(posedge core_clk);
      ext_lock_wr <= 1'b0;
      axr(`BFAP_OFF_LOCK, rd, rsp);
      chk("lock_tight", rd, 32'h0000_002C);
      erase();
      axr(`BFAP_OFF_LOCK, rd, rsp);
      chk("lock_erase", rd, 32'h0000_003F);
      $display("test irq_and_locks done");
      give_verdict();
   end
endmodule : tb
